// [design/bit_fifo.sv]
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module bit_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             empty;
  logic             full;

  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                     (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr_r <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule

// [design/sbm_host.sv]
// Host controller driving a one-bit serial memory through its strobes.
`timescale 1ns/1ns
`include "sbm_regs.svh"

// What this block does
// - Start address picks a 1024-word block only.
// - Address goes out serially as 13 bits.
// - Thirteenth dummy bit driven to a defined level.
// - Write select high reads, low writes.
// - Write select falling during access means read-modify-write.
// - Wait at least 1 ms after power-up.
// - Then issue ten dummy read cycles.
module sbm_host
  import sbm_pkg::*;
#(
  parameter int PAUSE_CYCLES = `SBM_PAUSE_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CMD_VALID,
  output logic             CMD_READY,
  input  wire logic [1:0]  CMD_OP,
  input  wire logic [11:0] CMD_ADDR,
  input  wire logic        CMD_WDATA,
  output logic             RD_VALID,
  input  wire logic        RD_READY,
  output logic             RD_DATA,
  output logic             INIT_DONE,
  output logic             ACCESS_CLOCK_N,
  output logic             ADDRESS_SHIFT_STROBE_N,
  output logic             COUNTER_LOAD_STROBE_N,
  output logic             ADDRESS_SERIAL_IN,
  output logic             WRITE_SELECT,
  output logic             DEVICE_SELECT_N,
  output logic             MEM_DATA_IN,
  input  wire logic        MEM_DATA_OUT
);
  localparam logic [3:0] STEP_CYC  = 4'(`SBM_STEP_CYC);
  localparam logic [5:0] STEP_TK   = 6'(`SBM_TICKS(`SBM_STEP_NS));
  localparam logic [5:0] RW_TK     = 6'(`SBM_TICKS(`SBM_RW_NS));
  localparam logic [5:0] RWP_TK    = 6'(`SBM_TICKS(`SBM_RWP_NS));
  localparam logic [3:0] LAST_BIT  = 4'(`SBM_ADDR_BITS - 1);
  localparam logic [3:0] LAST_DUMMY = 4'(`SBM_DUMMY_READS - 1);
  localparam logic [31:0] PAUSE_LAST = 32'(PAUSE_CYCLES - 1);

  sbm_state_t  state_r;
  sbm_op_t     op_r;
  logic [3:0]  div_r;
  logic        tick;
  logic [5:0]  timer_r;
  logic        phase_done;
  logic [31:0] pause_cnt_r;
  logic [3:0]  dummy_cnt_r;
  logic [3:0]  bit_cnt_r;
  logic [12:0] addr_sh_r;
  logic        rbit_r;
  logic        init_done_r;
  logic        dout_s1_r;
  logic        dout_s2_r;
  logic        fifo_in_ready;
  logic        fifo_push;
  logic        cmd_fire;
  logic        acc_n_r;
  logic        sas_n_r;
  logic        tas_n_r;
  logic        sad_r;
  logic        we_r;
  logic        cs_n_r;
  logic        din_r;

  // Every strobe phase is timed in ticks of 13 clocks (50 ns rounded up to 52 ns) so one timer serves all.
  assign tick       = (div_r == STEP_CYC - 4'h1);
  assign phase_done = tick && (timer_r == 6'h0);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      div_r <= 4'h0;
    end else if (tick) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dout_s1_r <= 1'b0;
      dout_s2_r <= 1'b0;
    end else begin
      dout_s1_r <= MEM_DATA_OUT;
      dout_s2_r <= dout_s1_r;
    end
  end

  // Reads need a free FIFO slot up front, so a result is never dropped.
  assign CMD_READY = (state_r == S_IDLE) && init_done_r &&
                     (CMD_OP == OP_LOAD || CMD_OP == OP_WRITE ||
                      fifo_in_ready);
  assign cmd_fire  = CMD_VALID && CMD_READY;
  assign fifo_push = phase_done && (state_r == S_ACC_HIGH) &&
                     init_done_r && (op_r != OP_WRITE);

  // The timer is loaded with whole ticks; the first tick may be partial,
  // so each phase lasts at least its figure and at most one tick more.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_r     <= S_PAUSE;
      op_r        <= OP_READ;
      timer_r     <= 6'h0;
      pause_cnt_r <= 32'h0;
      dummy_cnt_r <= 4'h0;
      bit_cnt_r   <= 4'h0;
      addr_sh_r   <= 13'h0;
      rbit_r      <= 1'b0;
      init_done_r <= 1'b0;
      acc_n_r     <= 1'b1;
      sas_n_r     <= 1'b1;
      tas_n_r     <= 1'b1;
      sad_r       <= 1'b0;
      we_r        <= 1'b1;
      cs_n_r      <= 1'b1;
      din_r       <= 1'b0;
    end else begin
      if (tick && timer_r != 6'h0) begin
        timer_r <= timer_r - 6'h1;
      end
      case (state_r)
        S_PAUSE: begin
          pause_cnt_r <= pause_cnt_r + 32'h1;
          if (pause_cnt_r == PAUSE_LAST) begin
            op_r    <= OP_READ;
            we_r    <= 1'b1;
            cs_n_r  <= 1'b0;
            timer_r <= STEP_TK;
            state_r <= S_ACC_SETUP;
          end
        end
        S_IDLE: begin
          cs_n_r <= 1'b1;
          if (cmd_fire && CMD_OP == OP_LOAD) begin
            // Twelve block bits then a zero dummy; no word offset exists.
            addr_sh_r <= {1'b0, CMD_ADDR};
            sad_r     <= CMD_ADDR[0];
            bit_cnt_r <= 4'h0;
            cs_n_r    <= 1'b0;
            timer_r   <= STEP_TK;
            state_r   <= S_SHIFT_SET;
          end else if (cmd_fire) begin
            op_r    <= sbm_op_t'(CMD_OP);
            we_r    <= (CMD_OP != OP_WRITE);
            din_r   <= CMD_WDATA;
            cs_n_r  <= 1'b0;
            timer_r <= STEP_TK;
            state_r <= S_ACC_SETUP;
          end
        end
        S_SHIFT_SET: begin
          if (phase_done) begin
            sas_n_r <= 1'b0;
            timer_r <= STEP_TK;
            state_r <= S_SHIFT_LOW;
          end
        end
        S_SHIFT_LOW: begin
          if (phase_done) begin
            sas_n_r <= 1'b1;
            timer_r <= STEP_TK;
            state_r <= S_SHIFT_HIGH;
          end
        end
        S_SHIFT_HIGH: begin
          if (phase_done && bit_cnt_r == LAST_BIT) begin
            tas_n_r <= 1'b0;
            timer_r <= STEP_TK;
            state_r <= S_XFER_LOW;
          end else if (phase_done) begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
            addr_sh_r <= {1'b0, addr_sh_r[12:1]};
            sad_r     <= addr_sh_r[1];
            timer_r   <= STEP_TK;
            state_r   <= S_SHIFT_SET;
          end
        end
        S_XFER_LOW: begin
          if (phase_done) begin
            tas_n_r <= 1'b1;
            timer_r <= STEP_TK;
            state_r <= S_XFER_HIGH;
          end
        end
        S_XFER_HIGH: begin
          if (phase_done) begin
            cs_n_r  <= 1'b1;
            state_r <= S_IDLE;
          end
        end
        S_ACC_SETUP: begin
          if (phase_done) begin
            acc_n_r <= 1'b0;
            timer_r <= RW_TK;
            state_r <= S_ACC_LOW;
          end
        end
        S_ACC_LOW: begin
          if (phase_done) begin
            // The access time has passed, so the output bit is settled.
            rbit_r <= dout_s2_r;
            if (op_r == OP_RMW) begin
              we_r    <= 1'b0;
              timer_r <= STEP_TK;
              state_r <= S_RMW_WE;
            end else begin
              acc_n_r <= 1'b1;
              timer_r <= RWP_TK;
              state_r <= S_ACC_HIGH;
            end
          end
        end
        S_RMW_WE: begin
          if (phase_done) begin
            acc_n_r <= 1'b1;
            timer_r <= RWP_TK;
            state_r <= S_ACC_HIGH;
          end
        end
        S_ACC_HIGH: begin
          if (phase_done) begin
            we_r <= 1'b1;
            if (!init_done_r && dummy_cnt_r != LAST_DUMMY) begin
              dummy_cnt_r <= dummy_cnt_r + 4'h1;
              timer_r     <= STEP_TK;
              state_r     <= S_ACC_SETUP;
            end else begin
              init_done_r <= 1'b1;
              cs_n_r      <= 1'b1;
              state_r     <= S_IDLE;
            end
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  assign ACCESS_CLOCK_N         = acc_n_r;
  assign ADDRESS_SHIFT_STROBE_N = sas_n_r;
  assign COUNTER_LOAD_STROBE_N  = tas_n_r;
  assign ADDRESS_SERIAL_IN      = sad_r;
  assign WRITE_SELECT           = we_r;
  assign DEVICE_SELECT_N        = cs_n_r;
  assign MEM_DATA_IN            = din_r;
  assign INIT_DONE              = init_done_r;

  bit_fifo #(
    .WIDTH (`SBM_FIFO_WIDTH),
    .DEPTH (`SBM_FIFO_DEPTH)
  ) u_rd_fifo (
    .clk       (MCLK),
    .rst       (RST),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rbit_r),
    .out_valid (RD_VALID),
    .out_ready (RD_READY),
    .out_data  (RD_DATA)
  );

endmodule

// [design/sbm_pkg.sv]
// Types shared by the serial bit memory host.
package sbm_pkg;

  typedef enum logic [1:0] {
    OP_LOAD  = 2'h0,
    OP_READ  = 2'h1,
    OP_WRITE = 2'h2,
    OP_RMW   = 2'h3
  } sbm_op_t;

  typedef enum logic [3:0] {
    S_PAUSE      = 4'h0,
    S_IDLE       = 4'h1,
    S_SHIFT_SET  = 4'h2,
    S_SHIFT_LOW  = 4'h3,
    S_SHIFT_HIGH = 4'h4,
    S_XFER_LOW   = 4'h5,
    S_XFER_HIGH  = 4'h6,
    S_ACC_SETUP  = 4'h7,
    S_ACC_LOW    = 4'h8,
    S_RMW_WE     = 4'h9,
    S_ACC_HIGH   = 4'ha
  } sbm_state_t;

endpackage

// [design/sbm_regs.svh]
// Timing and layout constants of the serial bit memory host.
`ifndef SBM_REGS_SVH
`define SBM_REGS_SVH

`define SBM_CLK_NS        4
`define SBM_STEP_NS       50
`define SBM_RW_NS         1600
`define SBM_RWP_NS        1000
`define SBM_PAUSE_NS      1000000
`define SBM_DUMMY_READS   10
`define SBM_ADDR_BITS     13
`define SBM_BLOCK_BITS    12
`define SBM_FIFO_WIDTH    1
`define SBM_FIFO_DEPTH    16

`define SBM_STEP_CYC  ((`SBM_STEP_NS + `SBM_CLK_NS - 1) / `SBM_CLK_NS)
`define SBM_TICKS(ns) (((ns) + `SBM_STEP_NS - 1) / `SBM_STEP_NS)
`define SBM_PAUSE_CYC ((`SBM_PAUSE_NS + `SBM_CLK_NS - 1) / `SBM_CLK_NS)

`endif

// [sim/sbm_host_asserts.sv]
// Protocol checker for the serial memory host pins.
`timescale 1ns/1ns
module sbm_host_asserts #(
  parameter int PAUSE_CYCLES = 50
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic INIT_DONE,
  input wire logic ACCESS_CLOCK_N,
  input wire logic ADDRESS_SHIFT_STROBE_N,
  input wire logic COUNTER_LOAD_STROBE_N,
  input wire logic ADDRESS_SERIAL_IN,
  input wire logic WRITE_SELECT,
  input wire logic DEVICE_SELECT_N,
  input wire logic MEM_DATA_IN,
  input wire logic RD_VALID,
  input wire logic RD_READY
);
  int   up;
  int   nf;
  int   ns;
  logic cp;
  logic sp;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      up <= 0;
      nf <= 0;
      ns <= 0;
      cp <= 1'b1;
      sp <= 1'b1;
    end else begin
      cp <= ACCESS_CLOCK_N;
      sp <= ADDRESS_SHIFT_STROBE_N;
      if (up < PAUSE_CYCLES) up <= up + 1;
      if (cp && !ACCESS_CLOCK_N && nf < 99) nf <= nf + 1;
      // Shift pulses are counted from the last counter load.
      if (!COUNTER_LOAD_STROBE_N) ns <= 0;
      else if (sp && !ADDRESS_SHIFT_STROBE_N) ns <= ns + 1;
    end
  end
  AST_PAUSE: assert property (
    !ACCESS_CLOCK_N |-> up >= PAUSE_CYCLES) else $error("early access");
  AST_DUMMY: assert property (
    $rose(INIT_DONE) |-> nf >= 10) else $error("too few dummy reads");
  AST_DUMMY_RD: assert property (
    !INIT_DONE && !ACCESS_CLOCK_N |-> WRITE_SELECT) else $error("dummy write");
  AST_LOAD13: assert property (
    $fell(COUNTER_LOAD_STROBE_N) |-> ns == 13) else $error("shift count");
  AST_SAD_HOLD: assert property (
    !ADDRESS_SHIFT_STROBE_N |-> $stable(ADDRESS_SERIAL_IN) &&
    COUNTER_LOAD_STROBE_N && ACCESS_CLOCK_N) else $error("address moved");
  AST_SEL: assert property (
    !ACCESS_CLOCK_N |-> !DEVICE_SELECT_N) else $error("access deselected");
  AST_WE: assert property (
    !ACCESS_CLOCK_N |-> !$rose(WRITE_SELECT)) else $error("select rose");
  AST_DIN: assert property (
    !ACCESS_CLOCK_N |-> $stable(MEM_DATA_IN)) else $error("write data moved");
  cover property ($fell(WRITE_SELECT) && !ACCESS_CLOCK_N);
  cover property ($fell(COUNTER_LOAD_STROBE_N));
  cover property (RD_VALID && !RD_READY && !ACCESS_CLOCK_N);
endmodule
bind sbm_host sbm_host_asserts #(.PAUSE_CYCLES(PAUSE_CYCLES)) asserts_inst (
  .MCLK, .RST, .INIT_DONE, .ACCESS_CLOCK_N, .ADDRESS_SHIFT_STROBE_N,
  .COUNTER_LOAD_STROBE_N, .ADDRESS_SERIAL_IN, .WRITE_SELECT,
  .DEVICE_SELECT_N, .MEM_DATA_IN, .RD_VALID, .RD_READY);

// [sim/sbm_mem_model.sv]
// Behavioural model of the one-bit serial memory seen by the host.
`timescale 1ns/1ns
module sbm_mem_model (
  input  wire logic ck_n,
  input  wire logic sas_n,
  input  wire logic tas_n,
  input  wire logic address_serial_in,
  input  wire logic we,
  input  wire logic cs_n,
  input  wire logic din,
  output logic      dout
);
  logic [12:0] sr = '0;
  logic [21:0] cnt = '0;
  logic        mem [int];
  logic        q = 1'b0;
  logic        drv = 1'b0;
  logic        ok = 1'b0;
  logic        wd = 1'b0;
  // Until the access time and once released the pin shows the inverse.
  assign dout = (drv && ok && !ck_n && !cs_n) ? q : ~q;
  always @(negedge sas_n) if (!cs_n) sr <= {address_serial_in, sr[12:1]};
  always @(negedge tas_n) if (!cs_n) cnt <= {sr[11:0], 10'h0};
  always @(negedge ck_n) if (!cs_n) begin
    q = mem.exists(cnt) ? mem[cnt] : ^cnt;
    wd = din;
    drv = we;
    ok = 1'b0;
    ok <= #1500 1'b1;
  end
  always @(negedge we) if (!cs_n && !ck_n) wd = din;
  always @(posedge ck_n) if (!cs_n) begin
    if (!we) mem[cnt] = wd;
    cnt = cnt + 22'h1;
  end
endmodule

// [sim/tb.sv]
// Self-checking bench of the serial memory host with a memory model.
`timescale 1ns/1ns
module tb;
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        CMD_VALID = 1'b0;
  logic [1:0]  CMD_OP = 2'h0;
  logic [11:0] CMD_ADDR = 12'h000;
  logic        CMD_WDATA = 1'b0;
  logic        RD_READY = 1'b0;
  logic        CMD_READY, RD_VALID, RD_DATA, INIT_DONE, ACCESS_CLOCK_N;
  logic        ADDRESS_SHIFT_STROBE_N, COUNTER_LOAD_STROBE_N;
  logic        ADDRESS_SERIAL_IN, WRITE_SELECT, DEVICE_SELECT_N;
  logic        MEM_DATA_IN, MEM_DATA_OUT;
  logic [7:0]  rs = 8'h4a;
  logic [11:0] blk;
  logic        ex [17];
  logic        nx [16];
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  always #2 MCLK = ~MCLK;
  sbm_host #(.PAUSE_CYCLES(50)) sbm_host_inst (.MCLK, .RST, .CMD_VALID,
    .CMD_READY, .CMD_OP, .CMD_ADDR, .CMD_WDATA, .RD_VALID, .RD_READY,
    .RD_DATA, .INIT_DONE, .ACCESS_CLOCK_N, .ADDRESS_SHIFT_STROBE_N,
    .COUNTER_LOAD_STROBE_N, .ADDRESS_SERIAL_IN, .WRITE_SELECT,
    .DEVICE_SELECT_N, .MEM_DATA_IN, .MEM_DATA_OUT);
  sbm_mem_model mem_inst (.ck_n(ACCESS_CLOCK_N),
    .sas_n(ADDRESS_SHIFT_STROBE_N), .tas_n(COUNTER_LOAD_STROBE_N),
    .address_serial_in(ADDRESS_SERIAL_IN), .we(WRITE_SELECT),
    .cs_n(DEVICE_SELECT_N), .din(MEM_DATA_IN), .dout(MEM_DATA_OUT));
  function automatic logic [7:0] lf(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Words never written read back as the parity of their address.
  function automatic logic dflt(logic [11:0] b, int i);
    logic [21:0] a;
    a = {b, 10'h000} + 22'(i);
    return ^a;
  endfunction
  task automatic check(string nm, logic e, logic s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmd(logic [1:0] op, logic [11:0] a, logic d);
    @(posedge MCLK) #1;
    CMD_VALID = 1'b1;
    CMD_OP = op;
    CMD_ADDR = a;
    CMD_WDATA = d;
    do @(negedge MCLK); while (CMD_READY !== 1'b1);
    @(posedge MCLK) #1 CMD_VALID = 1'b0;
  endtask
  task automatic pop(logic e);
    do @(negedge MCLK); while (RD_VALID !== 1'b1);
    check("RD_DATA", e, RD_DATA);
    @(posedge MCLK) #1 RD_READY = 1'b1;
    @(posedge MCLK) #1 RD_READY = 1'b0;
  endtask
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge MCLK);
    #1 RST = 1'b0;
    check("INIT_DONE", 1'b0, INIT_DONE);
    do @(negedge MCLK); while (INIT_DONE !== 1'b1);
    rs = lf(rs);
    blk = {rs, rs[3:0]};
    for (int i = 0; i < 17; i++) ex[i] = dflt(blk, i);
    cmd(2'h0, blk, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rs = lf(rs);
      ex[i] = rs[0];
      cmd(2'h2, 12'h000, rs[0]);
    end
    cmd(2'h0, blk, 1'b0);
    // Odd words go through read-modify-write and return the old bit.
    for (int i = 0; i < 16; i++) begin
      rs = lf(rs);
      nx[i] = i[0] ? rs[1] : ex[i];
      cmd(i[0] ? 2'h3 : 2'h1, 12'h000, rs[1]);
    end
    // The result queue is full, so a further read has to wait.
    fork
      cmd(2'h1, 12'h000, 1'b0);
      begin
        repeat (3000) @(negedge MCLK);
        check("CMD_READY", 1'b0, CMD_READY);
        for (int i = 0; i < 17; i++) pop(ex[i]);
      end
    join
    cmd(2'h0, blk, 1'b0);
    for (int i = 0; i < 4; i++) begin
      cmd(2'h1, 12'h000, 1'b0);
      pop(nx[i]);
    end
    check("RD_VALID", 1'b0, RD_VALID);
    print_verdict();
  end
endmodule
